// ===== hw/oamc_amp_decode.sv
`timescale 1ns/10ps
// per-amplifier decode of one control word into analog switch settings
module oamc_amp_decode (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [31:0] ctrl_in,
    input wire logic switch_in,
    output logic amp_on_out,
    output oamc_pkg::oamc_cfg_t cfg_out,
    output oamc_pkg::oamc_gain_t gain_out,
    output logic [2:0] pos_sel_out,
    output logic [1:0] neg_sel_out,
    output logic neg_to_output_out,
    output logic use_secondary_out
);
    oamc_pkg::oamc_cfg_t next_cfg;
    oamc_pkg::oamc_gain_t next_gain;
    logic [1:0] mode;
    logic next_secondary;

    assign mode = ctrl_in[oamc_pkg::mode_lsb +: 2];

    always_comb begin
        unique case (mode)
            oamc_pkg::mode_follow: next_cfg = oamc_pkg::oamc_cfg_follower;
            oamc_pkg::mode_pga: next_cfg = oamc_pkg::oamc_cfg_pga;
            default: next_cfg = oamc_pkg::oamc_cfg_external;
        endcase
        unique case (ctrl_in[oamc_pkg::gain_lsb +: 3])
            3'h1: next_gain = oamc_pkg::oamc_gain_4;
            3'h2: next_gain = oamc_pkg::oamc_gain_8;
            3'h3: next_gain = oamc_pkg::oamc_gain_16;
            3'h4: next_gain = oamc_pkg::oamc_gain_32;
            default: next_gain = oamc_pkg::oamc_gain_2;
        endcase
        // secondary only when auto switching is enabled and the timer is high
        next_secondary = ctrl_in[oamc_pkg::tmux_en_pos] && switch_in;
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            amp_on_out <= 1'b0;
            cfg_out <= oamc_pkg::oamc_cfg_external;
            gain_out <= oamc_pkg::oamc_gain_2;
            pos_sel_out <= 3'h0;
            neg_sel_out <= 2'h0;
            neg_to_output_out <= 1'b0;
            use_secondary_out <= 1'b0;
        end else if (enable_in) begin
            amp_on_out <= ctrl_in[oamc_pkg::enable_pos];
            cfg_out <= next_cfg;
            gain_out <= next_gain;
            use_secondary_out <= next_secondary;
            pos_sel_out <= next_secondary ? ctrl_in[oamc_pkg::pos_sec_lsb +: 3]
                                          : ctrl_in[oamc_pkg::pos_pri_lsb +: 3];
            neg_sel_out <= next_secondary ? ctrl_in[oamc_pkg::neg_sec_lsb +: 2]
                                          : ctrl_in[oamc_pkg::neg_pri_lsb +: 2];
            // follower ties the inverting input inside; the pin is free
            neg_to_output_out <= (next_cfg == oamc_pkg::oamc_cfg_follower);
        end
    end

    a_follow_feedback: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && mode == oamc_pkg::mode_follow |=> neg_to_output_out)
        else $error("follower feedback not connected");
    a_pga_cfg: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && mode == oamc_pkg::mode_pga |=> cfg_out == oamc_pkg::oamc_cfg_pga)
        else $error("pga mode not decoded");
    a_ext_cfg: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && !mode[1] |=> cfg_out == oamc_pkg::oamc_cfg_external && !neg_to_output_out)
        else $error("external mode not decoded");
    a_gain_default: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && ctrl_in[oamc_pkg::gain_lsb +: 3] > 3'h4 |=> gain_out == oamc_pkg::oamc_gain_2)
        else $error("illegal gain code not mapped to two");
    a_primary_only: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && !ctrl_in[oamc_pkg::tmux_en_pos]
        |=> !use_secondary_out && pos_sel_out == $past(ctrl_in[oamc_pkg::pos_pri_lsb +: 3]))
        else $error("secondary used with auto switching off");
    a_secondary_sel: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && ctrl_in[oamc_pkg::tmux_en_pos] && switch_in
        |=> use_secondary_out && neg_sel_out == $past(ctrl_in[oamc_pkg::neg_sec_lsb +: 2]))
        else $error("secondary selection not applied");
    c_follow: cover property (@(posedge clock_in) cfg_out == oamc_pkg::oamc_cfg_follower);
    c_switch: cover property (@(posedge clock_in) use_secondary_out ##1 !use_secondary_out);
endmodule // oamc_amp_decode

// ===== hw/oamc_axil_slave.sv
`timescale 1ns/10ps
// axi4-lite slave: one write and one read at a time, registered responses
module oamc_axil_slave (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [5:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [5:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic wr_strobe_out,
    output logic [5:0] wr_addr_out,
    output logic [31:0] wr_data_out,
    output logic [3:0] wr_strb_out,
    input wire logic wr_ok_in,
    output logic [5:0] rd_addr_out,
    input wire logic [31:0] rd_data_in,
    input wire logic rd_ok_in
);
    logic aw_held;
    logic w_held;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign awready_out = enable_in && !aw_held && !bvalid_out;
    assign wready_out = enable_in && !w_held && !bvalid_out;
    assign arready_out = enable_in && !rvalid_out;
    assign wr_strobe_out = enable_in && aw_held && w_held && !bvalid_out;
    assign wr_addr_out = aw_addr;
    assign wr_data_out = w_data;
    assign wr_strb_out = w_strb;
    assign rd_addr_out = araddr_in;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 6'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid_out <= 1'b0;
            bresp_out <= 2'h0;
        end else if (enable_in) begin
            if (awvalid_in && awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr_in;
            end
            if (wvalid_in && wready_out) begin
                w_held <= 1'b1;
                w_data <= wdata_in;
                w_strb <= wstrb_in;
            end
            if (wr_strobe_out) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid_out <= 1'b1;
                bresp_out <= wr_ok_in ? oamc_pkg::resp_okay : oamc_pkg::resp_slverr;
            end else if (bvalid_out && bready_in) begin
                bvalid_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= 2'h0;
        end else if (enable_in) begin
            if (arvalid_in && arready_out) begin
                rvalid_out <= 1'b1;
                rdata_out <= rd_data_in;
                rresp_out <= rd_ok_in ? oamc_pkg::resp_okay : oamc_pkg::resp_slverr;
            end else if (rvalid_out && rready_in) begin
                rvalid_out <= 1'b0;
            end
        end
    end
endmodule // oamc_axil_slave

// ===== hw/oamc_top.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module oamc_top (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic [5:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [5:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic timer_a_compare6_in,
    input wire logic timer_b_compare6_in,
    input wire logic [1:0] calibration_result_in,
    output logic [1:0] amp_on_out,
    output oamc_pkg::oamc_cfg_t amp1_cfg_out,
    output oamc_pkg::oamc_cfg_t amp2_cfg_out,
    output oamc_pkg::oamc_gain_t amp1_gain_out,
    output oamc_pkg::oamc_gain_t amp2_gain_out,
    output logic [2:0] amp1_pos_sel_out,
    output logic [2:0] amp2_pos_sel_out,
    output logic [1:0] amp1_neg_sel_out,
    output logic [1:0] amp2_neg_sel_out,
    output logic [1:0] neg_to_output_out,
    output logic [1:0] use_secondary_out,
    output logic [1:0] calibration_mode_on_out,
    output logic [1:0] high_range_out
);
    ////////////////////////////////////////////////////////////////////////
    logic wr_strobe;
    logic [5:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [5:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] amp1_control_status;
    logic [31:0] amp2_control_status;
    logic [1:0] amp_write_lock;
    logic [31:0] wr_bytes;
    logic amp2_switch;

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic addr_known(input logic [5:0] addr);
        addr_known = addr == oamc_pkg::amp1_control_status_off
                  || addr == oamc_pkg::amp2_control_status_off
                  || addr == oamc_pkg::amp_write_lock_off;
    endfunction

    assign wr_bytes = strb_mask(wr_strb);
    assign wr_ok = addr_known(wr_addr);
    assign rd_ok = addr_known(rd_addr);

    oamc_axil_slave u_bus (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .awaddr_in(awaddr_in),
        .awvalid_in(awvalid_in),
        .awready_out(awready_out),
        .wdata_in(wdata_in),
        .wstrb_in(wstrb_in),
        .wvalid_in(wvalid_in),
        .wready_out(wready_out),
        .bresp_out(bresp_out),
        .bvalid_out(bvalid_out),
        .bready_in(bready_in),
        .araddr_in(araddr_in),
        .arvalid_in(arvalid_in),
        .arready_out(arready_out),
        .rdata_out(rdata_out),
        .rresp_out(rresp_out),
        .rvalid_out(rvalid_out),
        .rready_in(rready_in),
        .wr_strobe_out(wr_strobe),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .wr_strb_out(wr_strb),
        .wr_ok_in(wr_ok),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // control registers; a locked register still answers okay, the write is dropped
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            amp1_control_status <= oamc_pkg::ctrl_reset;
        end else if (enable_in && wr_strobe && wr_addr == oamc_pkg::amp1_control_status_off
                     && !amp_write_lock[0]) begin
            amp1_control_status <= (amp1_control_status & ~(wr_bytes & oamc_pkg::amp1_wmask))
                                 | (wr_data & wr_bytes & oamc_pkg::amp1_wmask);
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            amp2_control_status <= oamc_pkg::ctrl_reset;
        end else if (enable_in && wr_strobe && wr_addr == oamc_pkg::amp2_control_status_off
                     && !amp_write_lock[1]) begin
            amp2_control_status <= (amp2_control_status & ~(wr_bytes & oamc_pkg::amp2_wmask))
                                 | (wr_data & wr_bytes & oamc_pkg::amp2_wmask);
        end
    end

    // lock bits only ever set; writing zero has no effect
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            amp_write_lock <= oamc_pkg::lock_reset;
        end else if (enable_in && wr_strobe && wr_addr == oamc_pkg::amp_write_lock_off && wr_strb[0]) begin
            amp_write_lock <= amp_write_lock | wr_data[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; calibration result is live status from the analog side
    always_comb begin
        unique case (rd_addr)
            oamc_pkg::amp1_control_status_off:
                rd_data = amp1_control_status
                        | ({31'h0000_0000, calibration_result_in[0]} << oamc_pkg::cal_result_pos);
            oamc_pkg::amp2_control_status_off:
                rd_data = amp2_control_status
                        | ({31'h0000_0000, calibration_result_in[1]} << oamc_pkg::cal_result_pos);
            oamc_pkg::amp_write_lock_off:
                rd_data = {30'h0000_0000, amp_write_lock};
            default:
                rd_data = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    assign amp2_switch = amp2_control_status[oamc_pkg::src_sel_pos]
                       ? timer_b_compare6_in : timer_a_compare6_in;

    oamc_amp_decode u_amp1 (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .ctrl_in(amp1_control_status),
        .switch_in(timer_a_compare6_in),
        .amp_on_out(amp_on_out[0]),
        .cfg_out(amp1_cfg_out),
        .gain_out(amp1_gain_out),
        .pos_sel_out(amp1_pos_sel_out),
        .neg_sel_out(amp1_neg_sel_out),
        .neg_to_output_out(neg_to_output_out[0]),
        .use_secondary_out(use_secondary_out[0])
    );

    oamc_amp_decode u_amp2 (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .ctrl_in(amp2_control_status),
        .switch_in(amp2_switch),
        .amp_on_out(amp_on_out[1]),
        .cfg_out(amp2_cfg_out),
        .gain_out(amp2_gain_out),
        .pos_sel_out(amp2_pos_sel_out),
        .neg_sel_out(amp2_neg_sel_out),
        .neg_to_output_out(neg_to_output_out[1]),
        .use_secondary_out(use_secondary_out[1])
    );

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            calibration_mode_on_out <= 2'h0;
            high_range_out <= 2'h0;
        end else if (enable_in) begin
            calibration_mode_on_out <= {amp2_control_status[oamc_pkg::cal_on_pos],
                                        amp1_control_status[oamc_pkg::cal_on_pos]};
            high_range_out <= {amp2_control_status[oamc_pkg::range_pos],
                               amp1_control_status[oamc_pkg::range_pos]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_lock_blocks_write: assert property (@(posedge clock_in) disable iff (reset_in)
        amp_write_lock[0] |=> $stable(amp1_control_status))
        else $error("locked amplifier one register changed");
    a_lock_blocks_two: assert property (@(posedge clock_in) disable iff (reset_in)
        amp_write_lock[1] |=> $stable(amp2_control_status))
        else $error("locked amplifier two register changed");
    a_lock_sticky: assert property (@(posedge clock_in) disable iff (reset_in)
        amp_write_lock[0] |=> amp_write_lock[0])
        else $error("lock bit cleared without reset");
    a_lock_never_falls: assert property (@(posedge clock_in) disable iff (reset_in)
        amp_write_lock[1] |=> amp_write_lock[1])
        else $error("lock bit fell");
    a_amp2_timer_b: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && amp2_control_status[oamc_pkg::src_sel_pos] && timer_b_compare6_in
        && amp2_control_status[oamc_pkg::tmux_en_pos] |=> use_secondary_out[1])
        else $error("amplifier two ignored timer b");
    a_amp2_timer_a: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && !amp2_control_status[oamc_pkg::src_sel_pos] && !timer_a_compare6_in
        |=> !use_secondary_out[1])
        else $error("amplifier two switched without timer a");
    a_enable_gate: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && !amp1_control_status[oamc_pkg::tmux_en_pos] |=> !use_secondary_out[0])
        else $error("amplifier one switched while disabled");
    c_lock_set: cover property (@(posedge clock_in) disable iff (reset_in) amp_write_lock == 2'h3);
    c_locked_write: cover property (@(posedge clock_in) disable iff (reset_in)
        wr_strobe && amp_write_lock[0] && wr_addr == oamc_pkg::amp1_control_status_off);
    c_timer_b: cover property (@(posedge clock_in) disable iff (reset_in)
        use_secondary_out == 2'h2 && amp2_control_status[oamc_pkg::src_sel_pos]);
endmodule // oamc_top

// ===== pkg/oamc_pkg.sv
package oamc_pkg;
    // register byte offsets
    localparam logic [5:0] amp1_control_status_off = 6'h00;
    localparam logic [5:0] amp2_control_status_off = 6'h10;
    localparam logic [5:0] amp_write_lock_off = 6'h20;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [1:0] lock_reset = 2'h0;
    // control field positions
    localparam int enable_pos = 0;
    localparam int mode_lsb = 1;
    localparam int gain_lsb = 3;
    localparam int neg_pri_lsb = 6;
    localparam int pos_pri_lsb = 8;
    localparam int cal_on_pos = 11;
    localparam int test_ref_pos = 13;
    localparam int cal_result_pos = 14;
    localparam int range_pos = 15;
    localparam int tmux_en_pos = 16;
    localparam int neg_sec_lsb = 17;
    localparam int pos_sec_lsb = 19;
    localparam int src_sel_pos = 24;
    // writable bits; bit 14 is a read-only status bit
    localparam logic [31:0] amp1_wmask = 32'h003f_afff;
    localparam logic [31:0] amp2_wmask = 32'h013f_afff;
    localparam logic [31:0] cal_result_mask = 32'h0000_4000;
    // mode codes and the floating negative-input select code
    localparam logic [1:0] mode_pga = 2'h2;
    localparam logic [1:0] mode_follow = 2'h3;
    localparam logic [1:0] neg_float = 2'h3;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    typedef enum logic [1:0] {oamc_cfg_external, oamc_cfg_follower, oamc_cfg_pga} oamc_cfg_t;
    typedef enum logic [2:0] {oamc_gain_2, oamc_gain_4, oamc_gain_8, oamc_gain_16, oamc_gain_32} oamc_gain_t;
endpackage

// ===== tb/oamc_top_tb.sv
`timescale 1ns/10ps
module oamc_top_tb;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic enable_in = 1'b1;
    logic [5:0] awaddr_in = 6'h00;
    logic [5:0] araddr_in = 6'h00;
    logic awvalid_in = 1'b0;
    logic wvalid_in = 1'b0;
    logic bready_in = 1'b0;
    logic arvalid_in = 1'b0;
    logic rready_in = 1'b0;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic [3:0] wstrb_in = 4'hf;
    logic timer_a_compare6_in = 1'b0;
    logic timer_b_compare6_in = 1'b0;
    logic [1:0] calibration_result_in = 2'h0;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic [1:0] bresp_out, rresp_out, amp_on_out, amp1_neg_sel_out, amp2_neg_sel_out, neg_to_output_out;
    logic [1:0] use_secondary_out, calibration_mode_on_out, high_range_out;
    logic [31:0] rdata_out;
    oamc_pkg::oamc_cfg_t amp1_cfg_out, amp2_cfg_out;
    oamc_pkg::oamc_gain_t amp1_gain_out, amp2_gain_out;
    logic [2:0] amp1_pos_sel_out, amp2_pos_sel_out;
    logic [31:0] v;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    oamc_top oamc_top_inst (.clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in),
        .awaddr_in(awaddr_in), .awvalid_in(awvalid_in), .awready_out(awready_out), .wdata_in(wdata_in),
        .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out), .bresp_out(bresp_out),
        .bvalid_out(bvalid_out), .bready_in(bready_in), .araddr_in(araddr_in), .arvalid_in(arvalid_in),
        .arready_out(arready_out), .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
        .rready_in(rready_in), .timer_a_compare6_in(timer_a_compare6_in),
        .timer_b_compare6_in(timer_b_compare6_in), .calibration_result_in(calibration_result_in),
        .amp_on_out(amp_on_out), .amp1_cfg_out(amp1_cfg_out), .amp2_cfg_out(amp2_cfg_out),
        .amp1_gain_out(amp1_gain_out), .amp2_gain_out(amp2_gain_out), .amp1_pos_sel_out(amp1_pos_sel_out),
        .amp2_pos_sel_out(amp2_pos_sel_out), .amp1_neg_sel_out(amp1_neg_sel_out),
        .amp2_neg_sel_out(amp2_neg_sel_out), .neg_to_output_out(neg_to_output_out),
        .use_secondary_out(use_secondary_out), .calibration_mode_on_out(calibration_mode_on_out),
        .high_range_out(high_range_out));

    initial begin
        forever #4 clock_in = ~clock_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // handshakes sampled at the falling edge, which sees what the next rising edge sees
    task automatic wr(input logic [5:0] addr, input logic [31:0] data);
        logic aw_t, w_t, b_t;
        logic [1:0] resp;
        @(posedge clock_in);
        awaddr_in <= addr;
        wdata_in <= data;
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge clock_in);
            aw_t = awvalid_in & awready_out;
            w_t = wvalid_in & wready_out;
            b_t = bvalid_out & bready_in;
            resp = bresp_out;
            @(posedge clock_in);
            if (aw_t) awvalid_in <= 1'b0;
            if (w_t) wvalid_in <= 1'b0;
        end
        bready_in <= 1'b0;
        chk(resp, oamc_pkg::resp_okay);
    endtask

    task automatic rd_chk(input logic [5:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic r_t, ar_t;
        logic [31:0] data;
        logic [1:0] resp;
        @(posedge clock_in);
        araddr_in <= addr;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge clock_in);
            ar_t = arvalid_in & arready_out;
            r_t = rvalid_out & rready_in;
            data = rdata_out;
            resp = rresp_out;
            @(posedge clock_in);
            if (ar_t) arvalid_in <= 1'b0;
        end
        rready_in <= 1'b0;
        chk(data, exp);
        chk(resp, exp_resp);
    endtask

    // decode outputs follow one edge after the register or timer change
    task automatic settle;
        repeat (2) @(negedge clock_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        rd_chk(oamc_pkg::amp1_control_status_off, 32'h0000_0000, oamc_pkg::resp_okay);
        rd_chk(oamc_pkg::amp2_control_status_off, 32'h0000_0000, oamc_pkg::resp_okay);
        rd_chk(oamc_pkg::amp_write_lock_off, 32'h0000_0000, oamc_pkg::resp_okay);
        rd_chk(6'h30, 32'h0000_0000, oamc_pkg::resp_slverr);
        for (int m = 0; m < 4; m++) begin
            wr(oamc_pkg::amp1_control_status_off, (32'(m) << oamc_pkg::mode_lsb) | 32'h1);
            settle();
            chk(amp1_cfg_out, m == 3 ? oamc_pkg::oamc_cfg_follower : m == 2 ? oamc_pkg::oamc_cfg_pga :
                oamc_pkg::oamc_cfg_external);
            chk(neg_to_output_out[0], m == 3);
        end
        for (int g = 0; g < 8; g++) begin
            wr(oamc_pkg::amp1_control_status_off, (32'(oamc_pkg::mode_pga) << oamc_pkg::mode_lsb) |
                (32'(oamc_pkg::neg_float) << oamc_pkg::neg_pri_lsb) |
                (32'(oamc_pkg::neg_float) << oamc_pkg::neg_sec_lsb) | (32'(g) << oamc_pkg::gain_lsb));
            settle();
            chk(amp1_gain_out, g > 4 ? 0 : g);
        end
        v = (32'h2 << oamc_pkg::pos_pri_lsb) | (32'h1 << oamc_pkg::neg_pri_lsb) |
            (32'h5 << oamc_pkg::pos_sec_lsb) | (32'h2 << oamc_pkg::neg_sec_lsb);
        @(posedge clock_in);
        timer_a_compare6_in <= 1'b1;
        wr(oamc_pkg::amp1_control_status_off, v);
        wr(oamc_pkg::amp2_control_status_off, v);
        settle();
        chk({amp1_pos_sel_out, amp1_neg_sel_out, use_secondary_out[0]}, {3'h2, 2'h1, 1'b0});
        wr(oamc_pkg::amp1_control_status_off, v | (32'h1 << oamc_pkg::tmux_en_pos));
        settle();
        chk({amp1_pos_sel_out, amp1_neg_sel_out, use_secondary_out[0]}, {3'h5, 2'h2, 1'b1});
        chk({amp2_pos_sel_out, amp2_neg_sel_out, use_secondary_out[1]}, {3'h2, 2'h1, 1'b0});
        wr(oamc_pkg::amp2_control_status_off, v | (32'h1 << oamc_pkg::tmux_en_pos));
        settle();
        chk({amp2_pos_sel_out, amp2_neg_sel_out, use_secondary_out[1]}, {3'h5, 2'h2, 1'b1});
        @(posedge clock_in);
        timer_a_compare6_in <= 1'b0;
        timer_b_compare6_in <= 1'b1;
        settle();
        chk({amp1_pos_sel_out, use_secondary_out}, {3'h2, 2'h0});
        wr(oamc_pkg::amp2_control_status_off, v | 32'h0101_0000);
        settle();
        chk({amp2_pos_sel_out, amp2_neg_sel_out, use_secondary_out}, {3'h5, 2'h2, 2'h2});
        @(posedge clock_in);
        timer_b_compare6_in <= 1'b0;
        calibration_result_in <= 2'h1;
        settle();
        chk({amp2_pos_sel_out, use_secondary_out[1]}, {3'h2, 1'b0});
        wr(oamc_pkg::amp_write_lock_off, 32'h1);
        wr(oamc_pkg::amp1_control_status_off, 32'h0000_0000);
        rd_chk(oamc_pkg::amp1_control_status_off, ((v | 32'h0001_0000) & oamc_pkg::amp1_wmask) |
            oamc_pkg::cal_result_mask, oamc_pkg::resp_okay);
        wr(oamc_pkg::amp2_control_status_off, v | 32'h0000_880f);
        settle();
        chk({amp_on_out, calibration_mode_on_out, high_range_out, neg_to_output_out}, 8'haa);
        chk({amp2_cfg_out, amp2_gain_out}, {oamc_pkg::oamc_cfg_follower, oamc_pkg::oamc_gain_4});
        rd_chk(oamc_pkg::amp2_control_status_off, (v | 32'h0000_880f) & oamc_pkg::amp2_wmask,
            oamc_pkg::resp_okay);
        wr(oamc_pkg::amp_write_lock_off, 32'h0);
        rd_chk(oamc_pkg::amp_write_lock_off, 32'h1, oamc_pkg::resp_okay);
        wr(oamc_pkg::amp_write_lock_off, 32'h2);
        rd_chk(oamc_pkg::amp_write_lock_off, 32'h3, oamc_pkg::resp_okay);
        @(posedge clock_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        rd_chk(oamc_pkg::amp_write_lock_off, 32'h0, oamc_pkg::resp_okay);
        rd_chk(oamc_pkg::amp1_control_status_off, oamc_pkg::cal_result_mask, oamc_pkg::resp_okay);
        print_verdict();
    end
endmodule // oamc_top_tb
